//--- inc/xim_pkg.sv
`default_nettype none
// ****************************************************************
// Constants and types of the shared vector mux and trap unit.
// ****************************************************************
package xim_pkg;
   // Register byte offsets on the bus.
   localparam logic [7:0] OFS_SEL0 = 8'h00; // Select register 0, the others follow by word.
   localparam logic [7:0] OFS_TFR = 8'h10; // Trap flag register.
   localparam logic [7:0] OFS_TSTAT = 8'h14; // Trap service status, read only.
   localparam int NVEC = 4; // Shared vectors.
   localparam int NSRC = 14; // Event sources.
   localparam logic [15:0] SEL_RST = 16'h0000; // Select register reset value.
   localparam logic [15:0] TFR_RST = 16'h0000; // Trap flag reset value.
   // Source indices.
   localparam logic [3:0] S_CAN_CONTROLLER_ONE = 4'h0, S_CAN_CONTROLLER_TWO = 4'h1, S_SECOND_PULSE_UNIT = 4'h2, S_I2RX = 4'h3;
   localparam logic [3:0] S_I2TX = 4'h4, S_SSRX = 4'h5, S_SSTX = 4'h6, S_ASRX = 4'h7;
   localparam logic [3:0] S_ASTX = 4'h8, S_ASTB = 4'h9, S_I2ER = 4'hA, S_SSER = 4'hB;
   localparam logic [3:0] S_ASER = 4'hC, S_UNLK = 4'hD, S_NONE = 4'hF;
   // Source feeding each flag bit of each vector, bit 7 first.
   localparam logic [3:0][7:0][3:0] SRC_MAP = '{
      '{S_NONE, S_UNLK, S_ASER, S_SSER, S_I2ER, S_SECOND_PULSE_UNIT, S_CAN_CONTROLLER_TWO, S_CAN_CONTROLLER_ONE},
      '{S_ASTB, S_ASTX, S_ASRX, S_SSTX, S_SSRX, S_I2TX, S_I2RX, S_SECOND_PULSE_UNIT},
      '{S_ASTB, S_ASTX, S_ASRX, S_SSTX, S_SSRX, S_I2TX, S_I2RX, S_CAN_CONTROLLER_TWO},
      '{S_ASTB, S_ASTX, S_ASRX, S_SSTX, S_SSRX, S_I2TX, S_I2RX, S_CAN_CONTROLLER_ONE}};
   // Trap flag bit positions.
   localparam int TF_NMI = 15, TF_STACK_OVER_FLAG = 14, TF_STACK_UNDER_FLAG = 13;
   localparam int TF_B0 = 0; // Class B flags sit in bits 5:0.
   // Vector locations and trap numbers.
   localparam logic [23:0] VEC_RESET = 24'h000000;
   localparam logic [23:0] VEC_NMI = 24'h000008;
   localparam logic [23:0] VEC_STACK_OVER_FLAG = 24'h000010;
   localparam logic [23:0] VEC_STACK_UNDER_FLAG = 24'h000018;
   localparam logic [23:0] VEC_B = 24'h000028;
   localparam logic [7:0] NUM_RESET = 8'h00, NUM_NMI = 8'h02, NUM_STACK_OVER_FLAG = 8'h04;
   localparam logic [7:0] NUM_STACK_UNDER_FLAG = 8'h06, NUM_B = 8'h0A;
   localparam logic [3:0] ILVL_MAX = 4'hF; // Forced priority level.
   // Service priority ranks.
   localparam logic [2:0] PRI_NONE = 3'h0, PRI_SW = 3'h1, PRI_B = 3'h2;
   localparam logic [2:0] PRI_A = 3'h3, PRI_RST = 3'h4;
   typedef enum logic [2:0] {
      XIM_IDLE = 3'b001,
      XIM_HWSVC = 3'b010,
      XIM_SWSVC = 3'b100
   } xim_state_e;
   // Trap requests from the core.
   typedef struct packed {
      logic sw_reset;
      logic wdt_ovf;
      logic nmi;
      logic stack_over_flag;
      logic stack_under_flag;
      logic [5:0] cls_b; // Order: bad_extbus, bad_fetch, bad_operand, protected_fault, muladd, bad_opcode.
      logic sw_trap;
      logic [6:0] sw_num;
      logic done;
   } xim_trap_in_s;
   // Trap branch towards the core.
   typedef struct packed {
      logic take;
      logic [23:0] vec;
      logic [7:0] num;
   } xim_trap_out_s;
endpackage
`default_nettype wire

//--- rtl/xim_unit.sv
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none
// Notes on behaviour
// - Four 16-bit select registers, indices 0-3.
// - High byte holds per-source enable bits.
// - Vector requests only from enabled flagged sources.
// - Flags set even while source disabled.
// - Receive/transmit sources on vectors 0-2 only.
// - Errors, unlock on 3; CAN, PWM fixed.
// - Resets go to 000000, number 00, top.
// - Class A traps have dedicated vectors.
// - Class B share vector 000028, number 0A.
// - Class A rank below resets, above B.
// - Six class B conditions, each own flag.
// - Priority level forced to 15 in hardware trap service.
// - Every hardware trap sets its flag bit.
// - Hardware trap service blocks interrupts; preemption.
module xim_unit
   import xim_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // AHB-Lite slave port.
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Peripheral event pulses.
   input wire logic [NSRC-1:0] src_evt_i,
   // Trap requests and the core's own priority level.
   input wire xim_trap_in_s trap_i,
   input wire logic [3:0] cpu_ilvl_i,
   // Towards the core.
   output logic [NVEC-1:0] shared_vector_o,
   output xim_trap_out_s trap_o,
   output logic [3:0] cpu_priority_level_o,
   output logic irq_block_o
);
   // ****************************************************************
   // State.
   // ****************************************************************
   typedef struct packed {
      logic [NVEC-1:0][15:0] sel; // Select registers.
      logic [15:0] trap_flag_register; // Trap flags.
      logic pend_rst; // Reset branch pending.
      logic [2:0] pend_a; // Class A pending, bit 0 highest.
      logic pend_b; // Class B pending.
      logic pend_sw; // Software trap pending.
      logic [6:0] sw_num; // Its number.
      logic [2:0] cur_pri; // Rank of the service in progress.
      xim_state_e state; // Service state.
      xim_trap_out_s tout; // Branch output.
      logic dph; // Bus data phase active.
      logic dwr; // Data phase is a write.
      logic [7:0] daddr; // Data phase address.
   } xim_st_s;

   xim_st_s st_r; // Registered state.
   xim_st_s st_nxt; // Its next value.
   logic [NVEC-1:0][7:0] vec_evt; // Events routed to each flag bit.
   logic hw_svc; // A hardware trap is being serviced.
   logic [31:0] rd_data; // Read mux result.

   // ****************************************************************
   // Source routing.
   // ****************************************************************
   // Each flag bit but bit 7 of vector 3 listens to one fixed source; a source absent from a
   // vector simply has no bit there, so it can never reach it.
   for (genvar v = 0; v < NVEC; v++) begin : g_vec
      for (genvar b = 0; b < 8; b++) begin : g_bit
         if (SRC_MAP[v][b] == S_NONE) begin : g_none
            assign vec_evt[v][b] = 1'b0;
         end else begin : g_src
            assign vec_evt[v][b] = src_evt_i[SRC_MAP[v][b]];
         end
      end
   end

   assign hw_svc = (st_r.state == XIM_HWSVC);

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   // Requests are gated by the enable byte and held off during hardware trap
   // service; pending flags stay and request again afterwards.
   always_comb begin
      for (int v = 0; v < NVEC; v++) begin
         shared_vector_o[v] = (|(st_r.sel[v][15:8] & st_r.sel[v][7:0])) && !hw_svc;
      end
   end

   // The level is overridden only for hardware traps and resets; a
   // software trap runs at the caller's level.
   assign cpu_priority_level_o = hw_svc ? ILVL_MAX : cpu_ilvl_i;
   assign irq_block_o = hw_svc;
   assign trap_o = st_r.tout;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = rd_data;

   // Read mux on the data phase address; unmapped words read zero.
   always_comb begin
      rd_data = 32'h00000000;
      if (st_r.dph && !st_r.dwr) begin
         case (st_r.daddr)
            OFS_SEL0, OFS_SEL0 + 8'h04, OFS_SEL0 + 8'h08, OFS_SEL0 + 8'h0C: begin
               rd_data = {16'h0000, st_r.sel[st_r.daddr[3:2]]};
            end
            OFS_TFR: begin
               rd_data = {16'h0000, st_r.trap_flag_register};
            end
            OFS_TSTAT: begin
               rd_data = {26'h0000000, st_r.cur_pri, st_r.state};
            end
            default: begin
               rd_data = 32'h00000000;
            end
         endcase
      end
   end

   // ****************************************************************
   // Next state.
   // ****************************************************************
   // Clears happen first and sets afterwards, so an event landing in
   // the same cycle as a software clear survives.
   always_comb begin
      logic [2:0] pick_pri;
      logic [23:0] pick_vec;
      logic [7:0] pick_num;
      logic sel_wr;
      pick_pri = PRI_NONE;
      pick_vec = VEC_RESET;
      pick_num = NUM_RESET;
      sel_wr = 1'b0;
      st_nxt = st_r;
      st_nxt.tout.take = 1'b0;
      // Bus address phase capture.
      st_nxt.dph = hsel_i && htrans_i[1] && hready_i;
      st_nxt.dwr = hwrite_i;
      st_nxt.daddr = haddr_i;
      // Data phase write.
      if (st_r.dph && st_r.dwr) begin
         sel_wr = (st_r.daddr[7:4] == OFS_SEL0[7:4]) && (st_r.daddr[1:0] == 2'b00);
         if (sel_wr) begin
            st_nxt.sel[st_r.daddr[3:2]][15:8] = hwdata_i[15:8];
            st_nxt.sel[st_r.daddr[3:2]][7:0] = st_r.sel[st_r.daddr[3:2]][7:0] & ~hwdata_i[7:0];
         end
         if (st_r.daddr == OFS_TFR) begin
            st_nxt.trap_flag_register = st_r.trap_flag_register & ~hwdata_i[15:0];
         end
      end
      // Flags follow events regardless of enables.
      for (int v = 0; v < NVEC; v++) begin
         st_nxt.sel[v][7:0] = st_nxt.sel[v][7:0] | vec_evt[v];
      end
      // Trap priority pick; the first hit wins.
      if (st_r.pend_rst) begin
         pick_pri = PRI_RST;
         pick_vec = VEC_RESET;
         pick_num = NUM_RESET;
      end else if (st_r.pend_a[0]) begin
         pick_pri = PRI_A;
         pick_vec = VEC_NMI;
         pick_num = NUM_NMI;
      end else if (st_r.pend_a[1]) begin
         pick_pri = PRI_A;
         pick_vec = VEC_STACK_OVER_FLAG;
         pick_num = NUM_STACK_OVER_FLAG;
      end else if (st_r.pend_a[2]) begin
         pick_pri = PRI_A;
         pick_vec = VEC_STACK_UNDER_FLAG;
         pick_num = NUM_STACK_UNDER_FLAG;
      end else if (st_r.pend_b) begin
         pick_pri = PRI_B;
         pick_vec = VEC_B;
         pick_num = NUM_B;
      end else if (st_r.pend_sw) begin
         pick_pri = PRI_SW;
         pick_vec = {15'h0000, st_r.sw_num, 2'b00};
         pick_num = {1'b0, st_r.sw_num};
      end
      // Service end returns to idle before any new pick is weighed.
      if (trap_i.done && st_r.state != XIM_IDLE) begin
         st_nxt.state = XIM_IDLE;
         st_nxt.cur_pri = PRI_NONE;
      end
      // A trap preempts only a service of strictly lower rank.
      if (pick_pri > st_nxt.cur_pri) begin
         st_nxt.tout.take = 1'b1;
         st_nxt.tout.vec = pick_vec;
         st_nxt.tout.num = pick_num;
         st_nxt.cur_pri = pick_pri;
         case (pick_pri)
            PRI_RST: begin
               st_nxt.pend_rst = 1'b0;
            end
            PRI_A: begin
               st_nxt.pend_a = st_r.pend_a & (st_r.pend_a - 3'h1);
            end
            PRI_B: begin
               st_nxt.pend_b = 1'b0;
            end
            default: begin
               st_nxt.pend_sw = 1'b0;
            end
         endcase
         st_nxt.state = (pick_pri == PRI_SW) ? XIM_SWSVC : XIM_HWSVC;
      end
      // New trap requests set pending and flag bits after the clears.
      if (trap_i.sw_reset || trap_i.wdt_ovf) begin
         st_nxt.pend_rst = 1'b1;
      end
      st_nxt.pend_a = st_nxt.pend_a | {trap_i.stack_under_flag, trap_i.stack_over_flag, trap_i.nmi};
      st_nxt.trap_flag_register[TF_NMI] = st_nxt.trap_flag_register[TF_NMI] | trap_i.nmi;
      st_nxt.trap_flag_register[TF_STACK_OVER_FLAG] = st_nxt.trap_flag_register[TF_STACK_OVER_FLAG] | trap_i.stack_over_flag;
      st_nxt.trap_flag_register[TF_STACK_UNDER_FLAG] = st_nxt.trap_flag_register[TF_STACK_UNDER_FLAG] | trap_i.stack_under_flag;
      st_nxt.trap_flag_register[TF_B0 +: 6] = st_nxt.trap_flag_register[TF_B0 +: 6] | trap_i.cls_b;
      if (|trap_i.cls_b) begin
         st_nxt.pend_b = 1'b1;
      end
      if (trap_i.sw_trap && !st_nxt.pend_sw) begin
         st_nxt.pend_sw = 1'b1;
         st_nxt.sw_num = trap_i.sw_num;
      end
   end

   // ****************************************************************
   // State register.
   // ****************************************************************
   // Reset leaves a reset branch pending, so the core is sent to the
   // reset vector right after release.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         st_r <= '0;
         st_r.sel <= {NVEC{SEL_RST}};
         st_r.trap_flag_register <= TFR_RST;
         st_r.pend_rst <= 1'b1;
         st_r.state <= XIM_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   chk_flag_masked: assert property (src_evt_i[S_CAN_CONTROLLER_ONE] |=> st_r.sel[0][0] && st_r.sel[3][0])
      else $error("Masked event lost its flag.");
   chk_vec3_excl: assert property (src_evt_i == 14'h0008 && !st_r.dph |=> $stable(st_r.sel[3][7:0]))
      else $error("Receive event reached vector 3.");
   chk_req_masked: assert property (!(|(st_r.sel[2][15:8] & st_r.sel[2][7:0])) |-> !shared_vector_o[2])
      else $error("Disabled source raised a vector.");
   chk_reset_vec: assert property (st_r.pend_rst |=> trap_o.take && trap_o.vec == VEC_RESET)
      else $error("Reset branch not taken at once.");
   chk_class_b: assert property (trap_o.take && trap_o.num == NUM_B |-> trap_o.vec == VEC_B)
      else $error("Class B vector wrong.");
   chk_a_over_b: assert property (st_r.pend_a != 3'h0 && st_r.pend_b && !st_r.pend_rst
      && st_r.state == XIM_IDLE |=> trap_o.take && trap_o.num != NUM_B)
      else $error("Class B taken ahead of class A.");
   chk_ilvl_force: assert property (trap_o.take && trap_o.num == NUM_NMI |-> cpu_priority_level_o == 4'hF)
      else $error("Level not forced in trap service.");
   chk_tfr_set: assert property (trap_i.cls_b[0] |=> st_r.trap_flag_register[TF_B0] ##1 st_r.trap_flag_register[TF_B0] || $past(st_r.dwr))
      else $error("Trap flag not set.");
   chk_no_irq: assert property (hw_svc |-> shared_vector_o == 4'h0)
      else $error("Interrupt during trap service.");
   chk_sw_vector: assert property (trap_o.take && st_r.state == XIM_SWSVC
      |-> trap_o.vec == {14'h0000, trap_o.num, 2'b00})
      else $error("Software trap vector wrong.");

   cov_masked_poll: cover property (st_r.sel[1][0] && !st_r.sel[1][8]);
   cov_hw_trap: cover property (trap_o.take && trap_o.num == NUM_STACK_OVER_FLAG);
   cov_sw_trap: cover property (trap_o.take && st_r.state == XIM_SWSVC);
   cov_preempt: cover property (hw_svc && st_r.cur_pri == PRI_B ##1 trap_o.take && trap_o.num == NUM_NMI);
endmodule // xim_unit
`default_nettype wire

//--- tb/xim_core_model.sv
`default_nettype none
// ****************************************************************
// Core side model: forwards trap requests and answers each branch with done unless a later take restarts its count.
// ****************************************************************
module xim_core_model
   import xim_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire xim_trap_in_s req_i,
   input wire logic take_i,
   input wire logic [3:0] dly_i,
   output xim_trap_in_s trap_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 0; // Cycles left in the handler, zero while no service is open.
   logic done_r = 1'b0; // One-cycle end of service.
   // A long delay keeps the service open, so preemption and blocking get time to show.
   always @(posedge clk_sys_i) begin
      done_r <= 1'b0;
      if (srst_i) begin
         cnt <= 0;
      end else if (take_i) begin
         cnt <= dly_i + 1;
      end else if (cnt == 1) begin
         done_r <= 1'b1;
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
   // Requests pass through untouched; only done is ours.
   always_comb begin
      trap_o = req_i;
      trap_o.done = done_r;
   end
endmodule // xim_core_model
`default_nettype wire

//--- tb/xbus_irq_mux_and_traps_tb_top.sv
`default_nettype none
module xbus_irq_mux_and_traps_tb_top;
   import xim_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys_i = 1'b0, srst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp, blk;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata, rd_q, q;
   logic [NSRC-1:0] src = '0;
   logic [3:0] ilvl = 4'h3, dly = 4'h1, sv, lvl;
   xim_trap_in_s req = '0, core_trap;
   xim_trap_out_s tro;
   int n_fail = 0, samples_checked = 0, seed = 32'hff91, men[4], mflg[4], mtfr = 0, n;
   xim_unit i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .src_evt_i(src), .trap_i(core_trap), .cpu_ilvl_i(ilvl),
      .shared_vector_o(sv), .trap_o(tro), .cpu_priority_level_o(lvl), .irq_block_o(blk));
   xim_core_model i_core (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .req_i(req), .take_i(tro.take),
      .dly_i(dly), .trap_o(core_trap));
   initial forever #5 clk_sys_i = ~clk_sys_i;
   // Read data is captured at the edge that closes the data phase, before any update lands.
   always @(posedge clk_sys_i) rd_q <= hrdata;
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single AHB-Lite transfer; the phases are held until hready is seen high.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
      do @(posedge clk_sys_i); while (hready !== 1'b1);
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
      do @(posedge clk_sys_i); while (hready !== 1'b1);
      #1 q = rd_q;
   endtask
   task automatic cmp_reg(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      cmp(q, e);
   endtask
   // Flag bit of source s on vector v, or -1 where the source is not wired to it.
   function automatic int bpos(int v, int s);
      if (v < 3) return (s == v) ? 0 : (s >= 3 && s <= 9) ? s - 2 : -1;
      return (s <= 2) ? s : (s >= 10 && s <= 13) ? s - 7 : -1;
   endfunction
   function automatic logic [3:0] exp_sv();
      for (int v = 0; v < 4; v++) exp_sv[v] = (men[v] & mflg[v]) != 0;
   endfunction
   task automatic pulse_src(int s);
      @(posedge clk_sys_i);
      src <= NSRC'(1) << s;
      @(posedge clk_sys_i);
      src <= '0;
      for (int v = 0; v < 4; v++) if (bpos(v, s) >= 0) mflg[v] |= 1 << bpos(v, s);
   endtask
   // Trap kinds: 0 soft reset, 1 watchdog, 2 nmi, 3 stack over, 4 stack under, 5..10 class B.
   task automatic fire(int k);
      @(posedge clk_sys_i);
      case (k)
         0: req.sw_reset <= 1'b1;
         1: req.wdt_ovf <= 1'b1;
         2: req.nmi <= 1'b1;
         3: req.stack_over_flag <= 1'b1;
         4: req.stack_under_flag <= 1'b1;
         default: req.cls_b[k-5] <= 1'b1;
      endcase
      @(posedge clk_sys_i);
      req <= '0;
   endtask
   task automatic wait_take(input logic [23:0] ev, input logic [7:0] en, input logic hw);
      int i;
      i = 0;
      do begin
         @(posedge clk_sys_i);
         #1 i++;
      end while (tro.take !== 1'b1 && i < 30);
      cmp(tro.take, 32'h1);
      cmp(tro.vec, ev);
      cmp(tro.num, en);
      cmp(lvl, hw ? 4'hF : ilvl);
      cmp(blk, hw);
      if (hw) cmp(sv, 32'h0);
      // Return one edge before the service closes: a pending trap is taken at that very edge,
      // and the next call must still see its one-cycle take pulse.
      repeat (dly + 2) @(posedge clk_sys_i);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog against a hang; the whole run needs under a thousand cycles.
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_fail++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      wait_take(24'h0, 8'h0, 1'b1);
      $display("test reset branch done");
      for (int v = 0; v < 4; v++) begin
         men[v] = (v == 3) ? 8'h55 : $random(seed) & 8'hFF;
         mflg[v] = 0;
         cmp_reg(8'(4 * v), 32'h0);
         bus(1'b1, 8'(4 * v), {16'h0, 8'(men[v]), 8'h00});
         cmp_reg(8'(4 * v), {16'h0, 8'(men[v]), 8'h00});
      end
      cmp_reg(8'h1C, 32'h0);
      cmp_reg(OFS_TSTAT, {26'h0, PRI_NONE, 3'b001});
      $display("test registers done");
      for (int s = 0; s < NSRC; s++) begin
         pulse_src(s);
         @(posedge clk_sys_i);
         #1 cmp(sv, exp_sv());
         for (int v = 0; v < 4; v++) cmp_reg(8'(4 * v), {16'h0, 8'(men[v]), 8'(mflg[v])});
         for (int v = 0; v < 4; v++) bus(1'b1, 8'(4 * v), {16'h0, 8'(men[v]), 8'hFF});
         for (int v = 0; v < 4; v++) mflg[v] = 0;
         cmp_reg(8'h00, {16'h0, 8'(men[0]), 8'h00});
      end
      $display("test event mapping done");
      men[0] = 1;
      bus(1'b1, 8'h00, 32'h0100);
      pulse_src(0);
      ilvl <= 4'($random(seed));
      dly <= 4'h9;
      for (int k = 2; k < 11; k++) begin
         fire(k);
         wait_take((k < 5) ? 24'(8 * (k - 1)) : 24'h28, (k < 5) ? 8'(2 * (k - 1)) : 8'h0A, 1'b1);
         mtfr = (k < 5) ? 1 << (17 - k) : 1 << (k - 5);
         cmp_reg(8'h10, 32'(mtfr));
         bus(1'b1, 8'h10, 32'hFFFF);
      end
      cmp(sv, exp_sv());
      $display("test hardware traps done");
      n = $random(seed) & 32'h7F;
      dly <= 4'h1;
      @(posedge clk_sys_i);
      req.nmi <= 1'b1; req.cls_b[3] <= 1'b1; req.sw_trap <= 1'b1; req.sw_num <= 7'(n);
      @(posedge clk_sys_i);
      req <= '0;
      wait_take(24'h8, 8'h02, 1'b1);
      wait_take(24'h28, 8'h0A, 1'b1);
      wait_take(24'(4 * n), 8'(n), 1'b0);
      $display("test priority done");
      for (int k = 0; k < 2; k++) begin
         fire(k);
         wait_take(24'h0, 8'h0, 1'b1);
      end
      $display("test reset kinds done");
      conclude();
   end
endmodule // xbus_irq_mux_and_traps_tb_top
`default_nettype wire
